// [logic/refresh_timer_pkg.sv]
// constants for the refresh interval timer and parity control block
// Notes on behaviour
// R1 - status register word write needs 0xa5 in upper byte; low byte stored.
// R2 - counter word write needs 0x69 in upper byte; low byte loaded.
// R3 - period constant word write needs 0x96 in upper byte; low byte stored.
// R4 - refresh control word write needs 0x5a in upper byte; low byte stored.
// R5 - wrong password leaves the protected register unchanged.
// R6 - byte writes to protected registers are ignored.
// R7 - reads by byte or word need no password; word upper byte reads zero except parity control.
// R8 - clock select: 000 stops, then divide by 2,8,32,128,512,2048,4096.
// R9 - counter is 8-bit up-counter on selected tick; upper byte reads zero.
// R10 - counter equal to constant clears counter and sets match flag.
// R11 - on match with refresh enable set, request a CAS-before-RAS refresh.
// R12 - interrupt request is match flag AND interrupt enable bit 6.
// R13 - match flag cleared only by writing zero after reading it as one.
// R14 - counter and status reset to zero by power-on reset only.
// R15 - period constant resets to 0x00ff; upper byte fixed zero.
// R16 - parity error sets flag bit 15; cleared by read-one then write-zero.
// R17 - parity force bit 14 drives both parity pins high on data output; the code does so only for accesses in the selected space.
// R18 - polarity bit 13: zero even parity, one odd parity.
// R19 - space field: 00 off, 01 DRAM only, 10 DRAM and area 2, 11 reserved.
// R20 - parity control resets to zero on power-on only; reserved bits read zero.
// R21 - with refresh disabled the counter is just an 8-bit interval timer.
// R22 - match clear beats a same-cycle counter write; flag still set.
package refresh_timer_pkg;
   // register selects
   localparam logic [1:0] sel_status = 2'h0;
   localparam logic [1:0] sel_count = 2'h1;
   localparam logic [1:0] sel_period = 2'h2;
   localparam logic [2:0] sel_w = 3'h3;
   localparam logic [2:0] reg_status = 3'h0;
   localparam logic [2:0] reg_count = 3'h1;
   localparam logic [2:0] reg_period = 3'h2;
   localparam logic [2:0] reg_refresh = 3'h3;
   localparam logic [2:0] reg_parity = 3'h4;
   // passwords
   localparam logic [7:0] pw_status = 8'ha5;
   localparam logic [7:0] pw_count = 8'h69;
   localparam logic [7:0] pw_period = 8'h96;
   localparam logic [7:0] pw_refresh = 8'h5a;
   // field positions
   localparam int match_flag_pos = 7;
   localparam int match_irq_enable_pos = 6;
   localparam int refresh_enable_pos = 7;
   localparam int parity_error_flag_pos = 15;
   localparam int parity_force_high_pos = 14;
   localparam int parity_polarity_pos = 13;
   // reset values and writable masks
   localparam logic [7:0] status_reset = 8'h00;
   localparam logic [7:0] count_reset = 8'h00;
   localparam logic [7:0] period_reset = 8'hff;
   localparam logic [7:0] refresh_reset = 8'h00;
   localparam logic [4:0] parity_reset = 5'h00;
   localparam logic [7:0] status_mask = 8'hf8;
   localparam logic [7:0] refresh_mask = 8'hf0;
   // prescaler width: divides up to 4096
   localparam int prescale_w = 12;
endpackage : refresh_timer_pkg

// [logic/parity_unit.sv]
// parity generation and checking for external DRAM data lanes
`timescale 1ns/100ps
module parity_unit
   import refresh_timer_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // settings
   input wire logic parity_force_high,
   input wire logic parity_polarity,
   input wire logic [1:0] parity_space,
   // access qualifiers
   input wire logic access_dram,
   input wire logic access_area2,
   input wire logic data_out_en,
   input wire logic read_strobe,
   input wire logic [15:0] bus_data,
   input wire logic parity_pin_upper_in,
   input wire logic parity_pin_lower_in,
   // results
   output logic parity_pin_upper,
   output logic parity_pin_lower,
   output logic parity_error_pulse
);
   // R19 space decode
   wire space_hit = (parity_space == 2'h1 && access_dram) ||
                    (parity_space == 2'h2 && (access_dram || access_area2));
   // R18 polarity applied to both lanes
   wire gen_upper = ^bus_data[15:8] ^ parity_polarity;
   wire gen_lower = ^bus_data[7:0] ^ parity_polarity;
   wire err_now = space_hit && read_strobe &&
                  ((gen_upper != parity_pin_upper_in) || (gen_lower != parity_pin_lower_in));
   // output pins registered
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         parity_pin_upper <= 1'b0;
         parity_pin_lower <= 1'b0;
         parity_error_pulse <= 1'b0;
      end
      else
      begin
         // R17 forced high for testing the checker
         parity_pin_upper <= data_out_en && space_hit && (parity_force_high || gen_upper);
         parity_pin_lower <= data_out_en && space_hit && (parity_force_high || gen_lower);
         parity_error_pulse <= err_now;
      end
   end
endmodule : parity_unit

// [logic/refresh_timer.sv]
// refresh interval timer with password-protected registers and parity control
`timescale 1ns/100ps
module refresh_timer
   import refresh_timer_pkg::*;
(
   // clock and power-on reset
   input wire logic core_clk,
   input wire logic nrst,
   // register access
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_word,
   input wire logic reg_byte_hi,
   input wire logic [2:0] reg_sel,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   // refresh and interrupt
   output logic refresh_request,
   output logic match_irq_request,
   // parity side
   input wire logic access_dram,
   input wire logic access_area2,
   input wire logic data_out_en,
   input wire logic read_strobe,
   input wire logic [15:0] bus_data,
   input wire logic parity_pin_upper_in,
   input wire logic parity_pin_lower_in,
   output logic parity_pin_upper,
   output logic parity_pin_lower
);
   logic [7:0] status_r;
   logic [7:0] count_r;
   logic [7:0] period_r;
   logic [7:0] refresh_r;
   logic [4:0] parity_r;
   logic [prescale_w-1:0] prescale_r;
   logic match_seen_r;
   logic perr_seen_r;
   logic tick_r;
   logic parity_error_pulse;

   // R6 only word writes qualify
   wire word_wr = reg_wr && reg_word;
   // R1 R2 R3 R4 R5 password compare
   wire wr_status = word_wr && reg_sel == reg_status && reg_wdata[15:8] == pw_status;
   wire wr_count = word_wr && reg_sel == reg_count && reg_wdata[15:8] == pw_count;
   wire wr_period = word_wr && reg_sel == reg_period && reg_wdata[15:8] == pw_period;
   wire wr_refresh = word_wr && reg_sel == reg_refresh && reg_wdata[15:8] == pw_refresh;
   // parity control is unprotected: word write, or byte write to the upper lane
   wire wr_parity = reg_wr && reg_sel == reg_parity && (reg_word || reg_byte_hi);
   wire [7:0] parity_wbyte = reg_word ? reg_wdata[15:8] : reg_wdata[7:0];

   // R8 clock select decode into a divider tap
   wire [2:0] clock_select = status_r[5:3];
   logic [prescale_w-1:0] tap_mask;
   always_comb
   begin
      unique case (clock_select)
         3'h0: tap_mask = 12'h000;
         3'h1: tap_mask = 12'h001;
         3'h2: tap_mask = 12'h007;
         3'h3: tap_mask = 12'h01f;
         3'h4: tap_mask = 12'h07f;
         3'h5: tap_mask = 12'h1ff;
         3'h6: tap_mask = 12'h7ff;
         3'h7: tap_mask = 12'hfff;
      endcase
   end
   wire tick_nxt = clock_select != 3'h0 && (prescale_r & tap_mask) == tap_mask;

   // R10 continuous compare
   wire match = count_r == period_r;
   // R13 clearing needs a prior read of one
   wire match_clear = wr_status && !reg_wdata[match_flag_pos] && match_seen_r;
   wire perr_clear = wr_parity && !parity_wbyte[7] && perr_seen_r;
   wire status_rd = reg_rd && reg_sel == reg_status && status_r[match_flag_pos];
   wire parity_rd = reg_rd && reg_sel == reg_parity && parity_r[4];

   // free-running prescaler; at select 0 it still runs but tick stays low
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         prescale_r <= '0;
      else
         prescale_r <= prescale_r + 12'h001;
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         tick_r <= 1'b0;
      else
         tick_r <= tick_nxt;
   end

   // R9 R22 counter: match clear wins over a software load
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         count_r <= count_reset;
      else if (match)
         count_r <= 8'h00;
      else if (wr_count)
         count_r <= reg_wdata[7:0];
      else if (tick_r)
         count_r <= count_r + 8'h01;
   end

   // R14 status; set of the flag beats its clear
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         status_r <= status_reset;
      else
      begin
         if (wr_status)
            status_r[6:0] <= reg_wdata[6:0] & status_mask[6:0];
         if (match)
            status_r[match_flag_pos] <= 1'b1;
         else if (match_clear)
            status_r[match_flag_pos] <= 1'b0;
      end
   end

   // remember that software saw the flag set
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         match_seen_r <= 1'b0;
         perr_seen_r <= 1'b0;
      end
      else
      begin
         match_seen_r <= status_rd || (match_seen_r && !match_clear && status_r[match_flag_pos]);
         perr_seen_r <= parity_rd || (perr_seen_r && !perr_clear && parity_r[4]);
      end
   end

   // R15 period constant
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         period_r <= period_reset;
      else if (wr_period)
         period_r <= reg_wdata[7:0];
   end

   // refresh control
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         refresh_r <= refresh_reset;
      else if (wr_refresh)
         refresh_r <= reg_wdata[7:0] & refresh_mask;
   end

   // R16 R20 parity control; error set beats clear
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         parity_r <= parity_reset;
      else
      begin
         if (wr_parity)
            parity_r[3:0] <= parity_wbyte[6:3];
         if (parity_error_pulse)
            parity_r[4] <= 1'b1;
         else if (perr_clear)
            parity_r[4] <= 1'b0;
      end
   end

   // R11 R21 one-cycle refresh request on each match when enabled
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         refresh_request <= 1'b0;
      else
         refresh_request <= match && refresh_r[refresh_enable_pos];
   end

   // R12 interrupt level
   assign match_irq_request = status_r[match_flag_pos] && status_r[match_irq_enable_pos];

   // R7 read mux, upper byte zero except parity control
   logic [15:0] rdata_nxt;
   always_comb
   begin
      unique case (reg_sel)
         reg_status: rdata_nxt = {8'h00, status_r};
         reg_count: rdata_nxt = {8'h00, count_r};
         reg_period: rdata_nxt = {8'h00, period_r};
         reg_refresh: rdata_nxt = {8'h00, refresh_r};
         reg_parity: rdata_nxt = {parity_r, 11'h000};
         default: rdata_nxt = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         reg_rdata <= 16'h0000;
      else if (reg_rd)
         reg_rdata <= rdata_nxt;
   end

   // parity generation and check
   parity_unit u_parity (
      .core_clk(core_clk),
      .nrst(nrst),
      .parity_force_high(parity_r[3]),
      .parity_polarity(parity_r[2]),
      .parity_space(parity_r[1:0]),
      .access_dram(access_dram),
      .access_area2(access_area2),
      .data_out_en(data_out_en),
      .read_strobe(read_strobe),
      .bus_data(bus_data),
      .parity_pin_upper_in(parity_pin_upper_in),
      .parity_pin_lower_in(parity_pin_lower_in),
      .parity_pin_upper(parity_pin_upper),
      .parity_pin_lower(parity_pin_lower),
      .parity_error_pulse(parity_error_pulse)
   );
endmodule : refresh_timer

// [verification/dram_parity_model.sv]
// far-side dram model: read data and parity pins
`timescale 1ns/100ps
module dram_parity_model
(
   // clock
   input wire logic core_clk,
   // bus phase from the bench
   input wire logic read_strobe,
   input wire logic parity_polarity,
   input wire logic inject,
   input wire logic [15:0] wr_data,
   // lines driven toward the block
   output logic [15:0] bus_data,
   output logic pin_u,
   output logic pin_l
);
   localparam logic [15:0] rd_word = 16'h3a17;
   logic [1:0] par;
   logic [1:0] last = 2'h0;
   assign par = {^rd_word[15:8], ^rd_word[7:0]} ^ {2{parity_polarity ^ inject}};
   // released pins show the inverse so a stale level never matches
   assign bus_data = read_strobe ? rd_word : wr_data;
   assign {pin_u, pin_l} = read_strobe ? par : ~last;
   // remember the last driven parity
   always_ff @(posedge core_clk)
      if (read_strobe)
         last <= par;
endmodule : dram_parity_model

// [verification/refresh_timer_properties.sv]
// port checker for the refresh timer block
`timescale 1ns/100ps
module refresh_timer_properties
   import refresh_timer_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // register read side
   input wire logic reg_rd,
   input wire logic [2:0] reg_sel,
   input wire logic [15:0] reg_rdata,
   // timer and parity outputs
   input wire logic refresh_request,
   input wire logic match_irq_request,
   input wire logic data_out_en,
   input wire logic parity_pin_upper,
   input wire logic parity_pin_lower
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   // one register read, answered on the next edge
   sequence s_rd(logic [2:0] s);
      reg_rd && reg_sel == s;
   endsequence
   property p_rst;
      disable iff (1'b0) !nrst |=> reg_rdata == 16'h0000 && !refresh_request && !match_irq_request;
   endproperty
   property p_hi;
      reg_rd && reg_sel < 3'h4 |=> reg_rdata[15:8] == 8'h00;
   endproperty
   property p_resv;
      reg_rd && reg_sel > 3'h4 |=> reg_rdata == 16'h0000;
   endproperty
   property p_stat;
      s_rd(reg_status) |=> reg_rdata[2:0] == 3'h0;
   endproperty
   property p_par;
      s_rd(reg_parity) |=> reg_rdata[10:0] == 11'h000;
   endproperty
   property p_stand;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   property p_pulse;
      refresh_request |=> !refresh_request;
   endproperty
   property p_pins;
      !data_out_en |=> !parity_pin_upper && !parity_pin_lower;
   endproperty
   // a flag read as set must agree with the request level
   property p_irq;
      s_rd(reg_status) |=> !reg_rdata[7] || match_irq_request == reg_rdata[6];
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
   a_hi: assert property (p_hi) else $error("upper byte of word read not zero");
   a_resv: assert property (p_resv) else $error("unmapped read not zero");
   a_stat: assert property (p_stat) else $error("status low bits not zero");
   a_par: assert property (p_par) else $error("parity reserved bits not zero");
   a_stand: assert property (p_stand) else $error("read data moved without read");
   a_pulse: assert property (p_pulse) else $error("refresh request longer than one cycle");
   a_pins: assert property (p_pins) else $error("parity pins high while idle");
   a_irq: assert property (p_irq) else $error("interrupt level disagrees with flags");
endmodule : refresh_timer_properties
bind refresh_timer refresh_timer_properties refresh_timer_properties_i (.core_clk, .nrst, .reg_rd, .reg_sel,
   .reg_rdata, .refresh_request, .match_irq_request, .data_out_en, .parity_pin_upper, .parity_pin_lower);

// [verification/refresh_timer_tb.sv]
// self-checking bench for the refresh timer block
`timescale 1ns/100ps
module refresh_timer_tb;
   import refresh_timer_pkg::*;
   logic core_clk, nrst, reg_wr, reg_rd, reg_word, reg_byte_hi, access_dram, access_area2;
   logic data_out_en, read_strobe, pin_u, pin_l, parity_pin_upper, parity_pin_lower;
   logic refresh_request, match_irq_request, polarity, inject;
   logic [2:0] reg_sel;
   logic [15:0] reg_wdata, reg_rdata, bus_data, wr_data;
   int errors, total_checks, pulses, gap, last, cyc;
   logic [7:0] pw [4] = '{pw_status, pw_count, pw_period, pw_refresh};
   logic [7:0] dat [4] = '{8'h40, 8'h05, 8'h10, 8'h30};
   logic [15:0] rst [6] = '{16'h0000, 16'h0000, 16'h00ff, 16'h0000, 16'h0000, 16'h0000};
   int dv [8] = '{0, 2, 8, 32, 128, 512, 2048, 4096};
   logic [15:0] pt [8] = '{16'h0800, 16'h2800, 16'h6800, 16'h1000, 16'h1000, 16'h0800, 16'h0000, 16'h1800};
   logic [3:0] pe [8] = '{4'h9, 4'ha, 4'hb, 4'h9, 4'h5, 4'h4, 4'h8, 4'h8};
   logic [16:0] ck [3] = '{17'h00800, 17'h02800, 17'h12800};
   refresh_timer refresh_timer_i (.core_clk, .nrst, .reg_wr, .reg_rd, .reg_word, .reg_byte_hi, .reg_sel,
      .reg_wdata, .reg_rdata, .refresh_request, .match_irq_request, .access_dram, .access_area2, .data_out_en,
      .read_strobe, .bus_data, .parity_pin_upper_in(pin_u), .parity_pin_lower_in(pin_l), .parity_pin_upper,
      .parity_pin_lower);
   dram_parity_model dram_parity_model_i (.core_clk, .read_strobe, .parity_polarity(polarity), .inject,
      .wr_data, .bus_data, .pin_u, .pin_l);
   // clock
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // refresh pulse spacing, sampled mid-cycle away from the edge
   always @(negedge core_clk)
   begin
      cyc++;
      if (refresh_request === 1'b1)
      begin
         gap = cyc - last;
         last = cyc;
         pulses++;
      end
   end
   task automatic wr(input logic [2:0] s, input logic [15:0] d, input logic w);
      @(negedge core_clk);
      reg_wr = 1'b1;
      reg_sel = s;
      reg_wdata = d;
      reg_word = w;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rc(input logic [2:0] s, input logic [15:0] e);
      @(negedge core_clk);
      reg_rd = 1'b1;
      reg_sel = s;
      @(negedge core_clk);
      reg_rd = 1'b0;
      chk($sformatf("reg%0d", s), e, reg_rdata);
   endtask : rc
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize
   // watchdog well past the longest divider sweep
   initial
   begin
      #600us;
      errors++;
      summarize();
   end
   initial
   begin
      {reg_wr, reg_rd, reg_word, reg_byte_hi, access_dram, access_area2} = 6'h00;
      {data_out_en, read_strobe, polarity, inject, nrst} = 5'h00;
      reg_sel = 3'h0;
      reg_wdata = 16'h0000;
      wr_data = 16'h0000;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      nrst = 1'b1;
      for (int i = 0; i < 6; i++)
         rc(i[2:0], rst[i]);
      // refused writes first, then the real password
      for (int i = 0; i < 4; i++)
      begin
         wr(i[2:0], {~pw[i], dat[i]}, 1'b1);
         wr(i[2:0], {pw[i], dat[i]}, 1'b0);
         rc(i[2:0], rst[i]);
         wr(i[2:0], {pw[i], dat[i]}, 1'b1);
         rc(i[2:0], {8'h00, dat[i]});
      end
      $display("test registers done");
      wr(reg_period, {pw_period, 8'h01}, 1'b1);
      wr(reg_count, {pw_count, 8'h00}, 1'b1);
      wr(reg_refresh, {pw_refresh, 8'h80}, 1'b1);
      for (int c = 1; c < 8; c++)
      begin
         wr(reg_status, {pw_status, 2'h0, c[2:0], 3'h0}, 1'b1);
         repeat (3 * dv[c] + 8) @(negedge core_clk);
         chk("gap", 16'h1, 16'(gap >= dv[c] - 1 && gap <= dv[c] + 2));
      end
      wr(reg_status, {pw_status, 8'h40}, 1'b1);
      rc(reg_status, 16'h00c0);
      chk("irq", 16'h1, {15'h0, match_irq_request});
      wr(reg_status, {pw_status, 8'h80}, 1'b1);
      rc(reg_status, 16'h0080);
      chk("irq", 16'h0, {15'h0, match_irq_request});
      wr(reg_status, {pw_status, 8'h00}, 1'b1);
      rc(reg_status, 16'h0000);
      wr(reg_refresh, {pw_refresh, 8'h00}, 1'b1);
      pulses = 0;
      wr(reg_status, {pw_status, 8'h08}, 1'b1);
      repeat (30) @(negedge core_clk);
      wr(reg_status, {pw_status, 8'h00}, 1'b1);
      chk("pulses", 16'h0, 16'(pulses));
      rc(reg_status, 16'h0080);
      // counter load in the same cycle as a match: the clear must win
      wr(reg_count, {pw_count, 8'h20}, 1'b1);
      @(negedge core_clk);
      {reg_wr, reg_word, reg_sel, reg_wdata} = {2'h3, reg_period, pw_period, 8'h20};
      @(negedge core_clk);
      {reg_sel, reg_wdata} = {reg_count, pw_count, 8'h33};
      @(negedge core_clk);
      reg_wr = 1'b0;
      rc(reg_count, 16'h0000);
      $display("test timer done");
      for (int i = 0; i < 8; i++)
      begin
         wr(reg_parity, pt[i], 1'b1);
         rc(reg_parity, pt[i]);
         @(negedge core_clk);
         {access_dram, access_area2, data_out_en} = {pe[i][3:2], 1'b1};
         wr_data = 16'h0301;
         @(negedge core_clk);
         data_out_en = 1'b0;
         chk("pins", {14'h0, pe[i][1:0]}, {14'h0, parity_pin_upper, parity_pin_lower});
      end
      for (int i = 0; i < 3; i++)
      begin
         wr(reg_parity, ck[i][15:0], 1'b1);
         @(negedge core_clk);
         {access_dram, access_area2, read_strobe} = 3'h5;
         {inject, polarity} = {ck[i][16], ck[i][13]};
         @(negedge core_clk);
         read_strobe = 1'b0;
         rc(reg_parity, ck[i][15:0] | {ck[i][16], 15'h0});
      end
      wr(reg_parity, 16'h2800, 1'b1);
      rc(reg_parity, 16'h2800);
      $display("test parity done");
      summarize();
   end
endmodule : refresh_timer_tb
